//--- charge_monitor_timebase.sv
`timescale 1ns/1ns
`default_nettype none
// Functional notes
// - Sense window stays active for 192 oscillator periods.
// - Sense windows repeat every 4096 oscillator periods.
// - Every converter and the converter enable share that single sense timing.
// - Charge current recognised only after persisting more than 32 periods.
// - Discharge load recognised only after persisting more than 20 periods.
// - While hot, self-discharge steps once per 2^35 or 2^36 periods.
// - Battery temperature sensing lasts 128 oscillator periods.
// - Battery temperature sensing repeats every 65536 oscillator periods.
// - Display test accepted only if held over 2^11, under 1.5*2^18.
// - Display test steps segments every 1024 oscillator periods.
// - Whole display test lasts 1.5*2^18 oscillator periods.
// - After non-exempt mode change, wait 512 periods, then LEDs lit 32768.
// - LCD backplane drive toggles at oscillator frequency over sixteen.
// - Auto buzzer output modulated at half the oscillator frequency.
module charge_monitor_timebase #(
  parameter int TEST_MAX_P   = charge_timebase_pkg::TEST_MAX,
  parameter int TEST_LEN_P   = charge_timebase_pkg::TEST_LEN,
  parameter int LED_ON_P     = charge_timebase_pkg::LED_ON,
  parameter int SELF_SHORT_P = charge_timebase_pkg::SELF_SHORT_LOG2,
  parameter int SELF_LONG_P  = charge_timebase_pkg::SELF_LONG_LOG2
) (
  input  wire logic clk,
  input  wire logic srst,
  input  wire logic ce,
  input  wire logic charge_present,
  input  wire logic load_present,
  input  wire logic temp_above_self,
  input  wire logic self_interval_sel,
  input  wire logic test_req,
  input  wire logic mode_change,
  input  wire logic led_hold_exempt_mode,
  input  wire logic buzzer_req,
  output logic      logic_clk_en,
  output logic      sense_window,
  output logic      converter_enable,
  output logic      charge_detected,
  output logic      load_detected,
  output logic      self_discharge_step,
  output logic      temp_window,
  output logic      display_test_active,
  output logic      display_step,
  output logic      led_on,
  output logic      lcd_backplane_drive,
  output logic      auto_buzzer_out
);
  import charge_timebase_pkg::*;

  localparam int HW = $clog2(TEST_MAX_P + 1);
  localparam int TW = $clog2(TEST_LEN_P + 1);
  localparam int LW = $clog2(LED_ON_P + 1);

  if (SELF_SHORT_P < 1 || SELF_SHORT_P > SELF_LONG_P || SELF_LONG_P > CHAIN_W) begin : bad_self
    $error("Self-discharge interval exponents out of range");
  end
  if (TEST_MAX_P <= TEST_MIN || TEST_LEN_P < (1 << TEST_STEP_LOG2)) begin : bad_test
    $error("Display test timing out of range");
  end
  if (LED_ON_P < 1 || LED_ON_P < LED_SU) begin : bad_led
    $error("LED on time out of range");
  end

  logic [CHAIN_W-1:0] chain;
  logic [CHAIN_W-1:0] next_chain;
  logic [5:0]         charge_cnt;
  logic [5:0]         load_cnt;
  logic [HW-1:0]      hold_cnt;
  logic               test_req_d;
  logic [TW-1:0]      test_cnt;
  logic [LW-1:0]      led_cnt;
  led_state_t         led_state;
  logic               self_tick;
  logic               test_accept;

  assign next_chain = chain + CHAIN_W'(1);

  // Free-running chain; every window is a decode of it
  always_ff @(posedge clk) begin
    if (srst)
      chain <= '0;
    else if (ce)
      chain <= next_chain;
  end

  // Outputs decoded from the next chain value so they leave flip-flops aligned
  always_ff @(posedge clk) begin
    if (srst) begin
      logic_clk_en        <= 1'b0;
      sense_window        <= 1'b0;
      converter_enable    <= 1'b0;
      temp_window         <= 1'b0;
      lcd_backplane_drive <= 1'b0;
      auto_buzzer_out     <= 1'b0;
    end else if (ce) begin
      logic_clk_en <= (next_chain[LOGIC_DIV_LOG2-1:0] == '0);
      sense_window <= (next_chain[SENSE_PER_LOG2-1:0]
                       < SENSE_PER_LOG2'(SENSE_ON));
      converter_enable <= (next_chain[SENSE_PER_LOG2-1:0]
                           < SENSE_PER_LOG2'(SENSE_ON));
      temp_window <= (next_chain[TEMP_PER_LOG2-1:0]
                      < TEMP_PER_LOG2'(TEMP_ON));
      lcd_backplane_drive <= next_chain[BP_BIT];
      auto_buzzer_out <= buzzer_req & next_chain[BUZ_BIT];
    end
  end

  // Persistence filters; a single gap restarts the count
  always_ff @(posedge clk) begin
    if (srst) begin
      charge_cnt      <= '0;
      charge_detected <= 1'b0;
    end else if (ce) begin
      if (!charge_present) begin
        charge_cnt      <= '0;
        charge_detected <= 1'b0;
      end else begin
        if (charge_cnt <= 6'(CHARGE_REC))
          charge_cnt <= charge_cnt + 6'(1);
        charge_detected <= (charge_cnt >= 6'(CHARGE_REC));
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      load_cnt      <= '0;
      load_detected <= 1'b0;
    end else if (ce) begin
      if (!load_present) begin
        load_cnt      <= '0;
        load_detected <= 1'b0;
      end else begin
        if (load_cnt <= 6'(LOAD_REC))
          load_cnt <= load_cnt + 6'(1);
        load_detected <= (load_cnt >= 6'(LOAD_REC));
      end
    end
  end

  // Select is assumed static; changing it mid-interval can shorten or lengthen one step
  assign self_tick = self_interval_sel ? (&chain[SELF_LONG_P-1:0])
                                       : (&chain[SELF_SHORT_P-1:0]);

  always_ff @(posedge clk) begin
    if (srst)
      self_discharge_step <= 1'b0;
    else if (ce)
      self_discharge_step <= temp_above_self & self_tick;
    else
      self_discharge_step <= 1'b0;
  end

  // Request judged on release, since only then is its length known
  assign test_accept = test_req_d && !test_req && !display_test_active
                       && (hold_cnt > HW'(TEST_MIN))
                       && (hold_cnt < HW'(TEST_MAX_P));

  always_ff @(posedge clk) begin
    if (srst) begin
      test_req_d <= 1'b0;
      hold_cnt   <= '0;
    end else if (ce) begin
      test_req_d <= test_req;
      if (!test_req)
        hold_cnt <= '0;
      else if (hold_cnt != HW'(TEST_MAX_P))
        hold_cnt <= hold_cnt + HW'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      display_test_active <= 1'b0;
      test_cnt            <= '0;
      display_step        <= 1'b0;
    end else if (ce) begin
      display_step <= 1'b0;
      if (test_accept) begin
        display_test_active <= 1'b1;
        test_cnt            <= '0;
      end else if (display_test_active) begin
        if (test_cnt == TW'(TEST_LEN_P - 1))
          display_test_active <= 1'b0;
        test_cnt <= test_cnt + TW'(1);
        display_step <= (&test_cnt[TEST_STEP_LOG2-1:0]);
      end
    end else begin
      display_step <= 1'b0;
    end
  end

  // A new non-exempt mode change restarts the set-up, even while lit
  always_ff @(posedge clk) begin
    if (srst) begin
      led_state <= LED_IDLE;
      led_cnt   <= '0;
      led_on    <= 1'b0;
    end else if (ce) begin
      if (mode_change && !led_hold_exempt_mode) begin
        led_state <= LED_SETUP;
        led_cnt   <= '0;
        led_on    <= 1'b0;
      end else begin
        case (led_state)
          LED_SETUP: begin
            if (led_cnt == LW'(LED_SU - 1)) begin
              led_state <= LED_LIT;
              led_cnt   <= '0;
              led_on    <= 1'b1;
            end else begin
              led_cnt <= led_cnt + LW'(1);
            end
          end
          LED_LIT: begin
            if (led_cnt == LW'(LED_ON_P - 1)) begin
              led_state <= LED_IDLE;
              led_cnt   <= '0;
              led_on    <= 1'b0;
            end else begin
              led_cnt <= led_cnt + LW'(1);
            end
          end
          default: begin
            led_state <= LED_IDLE;
            led_cnt   <= '0;
            led_on    <= 1'b0;
          end
        endcase
      end
    end
  end

  sequence mode_kick_s;
    ce && mode_change && !led_hold_exempt_mode;
  endsequence

  sequence test_release_s;
    test_accept && ce;
  endsequence

  logic_tick_a: assert property (@(posedge clk) disable iff (srst)
    logic_clk_en |-> chain[LOGIC_DIV_LOG2-1:0] == '0)
    else $error("Logic tick off the divide-by-64 boundary");

  sense_start_a: assert property (@(posedge clk) disable iff (srst)
    $rose(sense_window) |-> chain[SENSE_PER_LOG2-1:0] == '0
                            || (chain == CHAIN_W'(1) && $past(srst, 2)))
    else $error("Sense window did not open on the period boundary");

  sense_len_a: assert property (@(posedge clk) disable iff (srst)
    $fell(sense_window) |-> chain[SENSE_PER_LOG2-1:0] == SENSE_PER_LOG2'(SENSE_ON))
    else $error("Sense window length wrong");

  sense_shared_a: assert property (@(posedge clk) disable iff (srst)
    converter_enable == sense_window)
    else $error("Converter enable left the common sense timing");

  charge_rec_a: assert property (@(posedge clk) disable iff (srst)
    $rose(charge_detected) |-> charge_cnt == 6'(CHARGE_REC + 1))
    else $error("Charge recognised at wrong persistence");

  load_rec_a: assert property (@(posedge clk) disable iff (srst)
    load_detected && $past(ce) |-> $past(load_present) && load_cnt == 6'(LOAD_REC + 1))
    else $error("Load recognised without load present");

  self_step_a: assert property (@(posedge clk) disable iff (srst)
    self_discharge_step |-> $past(temp_above_self) && chain[SELF_SHORT_P-1:0] == '0)
    else $error("Self-discharge step off its interval");

  temp_window_a: assert property (@(posedge clk) disable iff (srst)
    temp_window |-> chain[TEMP_PER_LOG2-1:0] < TEMP_PER_LOG2'(TEMP_ON))
    else $error("Temperature window outside its slot");

  test_start_a: assert property (@(posedge clk) disable iff (srst)
    test_release_s |=> display_test_active && test_cnt == '0)
    else $error("Accepted display test did not start");

  test_step_a: assert property (@(posedge clk) disable iff (srst)
    display_step |-> test_cnt[TEST_STEP_LOG2-1:0] == '0 && $past(display_test_active))
    else $error("Display step off its interval");

  led_seq_a: assert property (@(posedge clk) disable iff (srst)
    mode_kick_s |=> !led_on && led_state == LED_SETUP && led_cnt == '0)
    else $error("Mode change did not restart LED set-up");

  bp_drive_a: assert property (@(posedge clk) disable iff (srst)
    ce |=> lcd_backplane_drive == chain[BP_BIT])
    else $error("Backplane drive not at oscillator over sixteen");

  buzzer_mod_a: assert property (@(posedge clk) disable iff (srst)
    auto_buzzer_out |-> chain[BUZ_BIT])
    else $error("Buzzer modulation off phase");

endmodule : charge_monitor_timebase
`default_nettype wire

//--- charge_monitor_timebase_test.sv
`timescale 1ns/1ns
`default_nettype none
module charge_monitor_timebase_test;
  import charge_timebase_pkg::*;
  logic clk, srst, ce, charge_present, load_present, temp_above_self, self_interval_sel;
  logic test_req, mode_change, led_hold_exempt_mode, buzzer_req;
  logic logic_clk_en, sense_window, converter_enable, charge_detected, load_detected;
  logic self_discharge_step, temp_window, display_test_active, display_step, led_on;
  logic lcd_backplane_drive, auto_buzzer_out;
  int   failures, comparisons, periods;
  charge_monitor_timebase #(.TEST_MAX_P(8192), .TEST_LEN_P(4096), .LED_ON_P(1024),
    .SELF_SHORT_P(6), .SELF_LONG_P(8)) i_charge_monitor_timebase (
    .clk(clk), .srst(srst), .ce(ce), .charge_present(charge_present),
    .load_present(load_present), .temp_above_self(temp_above_self),
    .self_interval_sel(self_interval_sel), .test_req(test_req), .mode_change(mode_change),
    .led_hold_exempt_mode(led_hold_exempt_mode), .buzzer_req(buzzer_req),
    .logic_clk_en(logic_clk_en), .sense_window(sense_window),
    .converter_enable(converter_enable), .charge_detected(charge_detected),
    .load_detected(load_detected), .self_discharge_step(self_discharge_step),
    .temp_window(temp_window), .display_test_active(display_test_active),
    .display_step(display_step), .led_on(led_on),
    .lcd_backplane_drive(lcd_backplane_drive), .auto_buzzer_out(auto_buzzer_out));
  initial begin
    clk = 0;
    forever #4 clk = ~clk;
  end
  task check_bit(input string what, input logic exp, input logic got);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
    end
  endtask : check_bit
  task check_count(input string what, input int exp, input int got);
    comparisons++;
    if (got != exp) begin
      failures++;
      $display("CHECK FAILED %s expected %0d seen %0d", what, exp, got);
    end
  endtask : check_count
  task wrap_up;
    if (failures == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : wrap_up
  // Windows are judged every cycle against a bench copy of the period count
  task check_windows;
    int per;
    per = self_interval_sel ? 256 : 64;
    check_bit("sense_window", periods % 4096 < 192, sense_window);
    check_bit("converter_enable", periods % 4096 < 192, converter_enable);
    check_bit("temp_window", periods % 65536 < 128, temp_window);
    check_bit("lcd_backplane_drive", periods % 16 >= 8, lcd_backplane_drive);
    check_bit("auto_buzzer_out", buzzer_req & periods[0], auto_buzzer_out);
    check_bit("self_discharge_step", ce & temp_above_self & (periods % per == 0),
              self_discharge_step);
    if (ce) check_bit("logic_clk_en", periods % 64 == 0, logic_clk_en);
  endtask : check_windows
  task cyc;
    @(posedge clk);
    if (ce) periods++;
    @(negedge clk);
    check_windows();
  endtask : cyc
  task do_reset;
    srst = 1;
    repeat (4) @(negedge clk);
    check_bit("outputs_in_reset", 1'b0, |{logic_clk_en, sense_window, charge_detected,
              load_detected, temp_window, display_test_active, led_on, auto_buzzer_out});
    srst = 0;
    periods = 0;
  endtask : do_reset
  task windows_run;
    repeat (2100) cyc;
    buzzer_req = 1;
    repeat (2100) cyc;
    buzzer_req = 0;
  endtask : windows_run
  // Hold n edges without detection, break once, then count to detection
  task filter_run(input bit is_load, input int n);
    int i;
    if (is_load) load_present = 1; else charge_present = 1;
    repeat (n) cyc;
    check_bit("not_yet", 1'b0, is_load ? load_detected : charge_detected);
    if (is_load) load_present = 0; else charge_present = 0;
    cyc;
    if (is_load) load_present = 1; else charge_present = 1;
    for (i = 1; i < 100; i++) begin
      cyc;
      if ((is_load ? load_detected : charge_detected) === 1'b1) break;
    end
    check_count("detect_edges", n + 1, i);
    if (is_load) load_present = 0; else charge_present = 0;
    cyc;
    check_bit("dropped", 1'b0, is_load ? load_detected : charge_detected);
  endtask : filter_run
  task test_run(input int hold, input logic accept);
    int i, first;
    first = 0;
    test_req = 1;
    repeat (hold) cyc;
    test_req = 0;
    cyc;
    check_bit("display_test_active", accept, display_test_active);
    for (i = 1; i < 5000 && display_test_active === 1'b1; i++) begin
      cyc;
      if (display_step === 1'b1 && first == 0) first = i;
    end
    if (accept) check_count("test_length", 4096, i - 1);
    if (accept) check_count("first_step", 1024, first);
  endtask : test_run
  task led_run(input logic exempt);
    int i, lit;
    lit = 0;
    led_hold_exempt_mode = exempt;
    mode_change = 1;
    cyc;
    mode_change = 0;
    for (i = 0; i < 600 && led_on !== 1'b1; i++) cyc;
    for (lit = 0; lit < 2000 && led_on === 1'b1; lit++) cyc;
    check_count("led_setup", exempt ? 600 : 512, i);
    check_count("led_lit", exempt ? 0 : 1024, lit);
    led_hold_exempt_mode = 0;
  endtask : led_run
  task self_run;
    temp_above_self = 1;
    repeat (600) cyc;
    do_reset();
    self_interval_sel = 1;
    repeat (600) cyc;
    ce = 0;
    repeat (10) cyc;
    ce = 1;
    temp_above_self = 0;
  endtask : self_run
  initial begin
    {srst, charge_present, load_present, temp_above_self, self_interval_sel} = '0;
    {test_req, mode_change, led_hold_exempt_mode, buzzer_req} = '0;
    ce = 1;
    failures = 0;
    comparisons = 0;
    periods = 0;
    @(negedge clk);
    do_reset();
    windows_run();
    filter_run(0, 32);
    filter_run(1, 20);
    test_run(2048, 1'b0);
    test_run(2049, 1'b1);
    test_run(8192, 1'b0);
    led_run(1'b0);
    led_run(1'b1);
    self_run();
    while (periods < 65736) cyc;
    wrap_up();
  end
  // Longest path is about ninety thousand cycles
  initial begin
    #780000;
    failures++;
    wrap_up();
  end
endmodule : charge_monitor_timebase_test
`default_nettype wire

//--- charge_timebase_pkg.sv
`default_nettype none
package charge_timebase_pkg;
  // All times are in oscillator periods; one enabled clk cycle is one period
  localparam int LOGIC_DIV_LOG2  = 6;
  localparam int SENSE_ON        = 192;
  localparam int SENSE_PER_LOG2  = 12;
  localparam int CHARGE_REC      = 32;
  localparam int LOAD_REC        = 20;
  localparam int TEMP_ON         = 128;
  localparam int TEMP_PER_LOG2   = 16;
  localparam int TEST_MIN        = 2048;
  localparam int TEST_MAX        = 393216;
  localparam int TEST_STEP_LOG2  = 10;
  localparam int TEST_LEN        = 393216;
  localparam int LED_SU          = 512;
  localparam int LED_ON          = 32768;
  localparam int BP_BIT          = 3;
  localparam int BUZ_BIT         = 0;
  localparam int SELF_SHORT_LOG2 = 35;
  localparam int SELF_LONG_LOG2  = 36;
  localparam int CHAIN_W         = 36;
  typedef enum logic [1:0] {LED_IDLE, LED_SETUP, LED_LIT} led_state_t;
endpackage : charge_timebase_pkg
`default_nettype wire
